// File: logic/mcu_reset_pkg.sv
// Purpose: shared constants and types of the reset controller
// Assumes: 40 MHz ref_clk, sub clock sampled as a plain level
// Notes: register map is one 32-bit word per register
// Summary of operation
// - power-on reset clears program counter
// - power-on presets port data and direction high
// - power-on and supply reset wait 50ms
// - pin release waits 16.7ms before running
// - pin reset only when option selects it
// - pin low resets, program restarts at zero
// - pin reset keeps a subset of registers
// - low supply in run resets whole device
// - short supply dips are ignored
// - threshold codes select five levels or off
// - undefined code resets, field restored
// - genuine supply reset keeps threshold register
// - sleep mode alone disables supply reset, halt does not
// - threshold loads 66h, bits 3:2 read-only
// - supply reset flag bit 2, cleared by zero
// - code fault flag bit 1, cleared by zero
// - cause bits 7 to 3 read zero
// - writing 55h to flash control resets
// - watchdog expiry in run: reset, expired flag
// - watchdog in sleep: clear PC, SP, set both flags
// - watchdog divider ratio 2^8 to 2^18
// - watchdog control fault flag bit 0
// - power-on clears expired and powerdown flags
package mcu_reset_pkg;
    localparam real CLK_FREQ_MHZ = 40.0;
    localparam real RESET_DELAY_LONG_MS = 50.0;
    localparam real RESET_DELAY_SHORT_MS = 16.7;
    localparam int unsigned RESET_DELAY_LONG_CYC =
        int'(RESET_DELAY_LONG_MS * 1000.0 * CLK_FREQ_MHZ);
    localparam int unsigned RESET_DELAY_SHORT_CYC =
        int'(RESET_DELAY_SHORT_MS * 1000.0 * CLK_FREQ_MHZ);
    localparam int DELAY_W = 21;
    localparam int TICK_W = 4;
    localparam logic [TICK_W-1:0] LOW_SUPPLY_QUAL_TICKS = 4'h3;
    localparam logic [TICK_W-1:0] CODE_FAULT_TICKS = 4'h2;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] THRESHOLD_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] CAUSE_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] FLASH_CTRL2_OFS = 12'h008;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h00C;

    localparam logic [7:0] THRESHOLD_RESET = 8'h66;
    localparam logic [7:0] THRESHOLD_WR_MASK = 8'hF3;
    localparam logic [7:0] THR_1V7 = 8'h66;
    localparam logic [7:0] THR_1V9 = 8'h55;
    localparam logic [7:0] THR_2V55 = 8'h33;
    localparam logic [7:0] THR_3V15 = 8'h99;
    localparam logic [7:0] THR_3V8 = 8'hAA;
    localparam logic [7:0] THR_OFF = 8'hF0;

    localparam int SUPPLY_FLAG_BIT = 2;
    localparam int CODE_FLAG_BIT = 1;
    localparam int WDT_CTRL_FLAG_BIT = 0;
    localparam logic [2:0] CAUSE_RESET = 3'h0;
    localparam logic [7:0] FLASH_RESET_KEY = 8'h55;
    localparam logic [7:0] FLASH_CTRL2_RESET = 8'h00;

    localparam int STAT_EXPIRED_BIT = 0;
    localparam int STAT_POWERDOWN_BIT = 1;
    localparam int STAT_ARMED_BIT = 2;
    localparam int STAT_HOLD_BIT = 3;
    localparam int STAT_SRC_LSB = 4;

    // division exponent per watchdog select code, code 0 lowest
    localparam logic [7:0][4:0] WDT_EXP_TABLE = {
        5'h12, 5'h11, 5'h10, 5'h0F, 5'h0E, 5'h0C, 5'h0A, 5'h08};

    typedef enum logic [2:0] {
        LVL_1V7, LVL_1V9, LVL_2V55, LVL_3V15, LVL_3V8, LVL_OFF, LVL_BAD
    } supply_level_t;

    typedef enum logic [2:0] {
        SRC_POWER_ON, SRC_PIN, SRC_LOW_SUPPLY, SRC_WDT, SRC_FLASH,
        SRC_CODE_FAULT, SRC_WDT_CTRL
    } reset_src_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic cpuHold;
        logic regInit;
        logic porInit;
        logic pcSpClear;
        logic portsPreset;
    } rst_ctrl_t;
endpackage : mcu_reset_pkg

// File: logic/supply_qualifier.sv
// Purpose: holds a condition for a count of sub-clock ticks
// Assumes: subTick is a one-cycle pulse per sub-clock rising edge
// Notes: a dropped condition restarts the count from zero
`timescale 1ns/1ps
module supply_qualifier (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // tick, condition and required length
    input wire logic subTick,
    input wire logic condition,
    input wire logic [mcu_reset_pkg::TICK_W-1:0] target,
    // condition held long enough
    output logic qualified
);
    import mcu_reset_pkg::*;

    logic [TICK_W-1:0] ticks;

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !condition) begin
            ticks <= '0;
        end else if (subTick && ticks != target) begin
            ticks <= ticks + 1'b1;
        end
    end

    // a dip shorter than target ticks never qualifies
    assign qualified = condition && ticks == target;

    a_dip_ignored: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !$past(condition) |-> !qualified)
        else $error("qualifier fired without a held condition");
    a_qual_on_tick: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(qualified) && $past(condition) |-> $past(subTick))
        else $error("qualifier fired off a sub-clock tick");
endmodule : supply_qualifier

// File: logic/mcu_reset_controller.sv
// Purpose: merges reset sources into one held device reset
// Assumes: all pins synchronous to ref_clk, sys_rst is power-on
// Notes: APB slave, zero wait states, data word from flops
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module mcu_reset_controller #(
    parameter int unsigned LONG_DELAY_CYC =
        mcu_reset_pkg::RESET_DELAY_LONG_CYC,
    parameter int unsigned SHORT_DELAY_CYC =
        mcu_reset_pkg::RESET_DELAY_SHORT_CYC
) (
    // clock and power-on reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register bus
    input wire mcu_reset_pkg::apb_req_t apbReq,
    output mcu_reset_pkg::apb_rsp_t apbRsp,
    // pins and configuration
    input wire logic externalResetPinN,
    input wire logic externalResetOptEn,
    input wire logic subClk,
    // supply detector
    input wire logic lowSupplyDetect,
    output mcu_reset_pkg::supply_level_t thresholdLevel,
    // core and watchdog events
    input wire logic sleepMode,
    input wire logic haltExec,
    input wire logic clearWatchdog,
    input wire logic watchdogTimeout,
    input wire logic watchdogCodeFault,
    input wire logic [2:0] watchdogSelect,
    output logic [4:0] watchdogDivExp,
    // reset controls and core flags
    output mcu_reset_pkg::rst_ctrl_t rstCtrl,
    output logic watchdogExpiredFlag,
    output logic powerdownFlag
);
    import mcu_reset_pkg::*;

    typedef enum logic [1:0] {SEQ_RUN, SEQ_HOLD, SEQ_DELAY} seq_state_t;

    seq_state_t state;
    seq_state_t next_state;
    logic [DELAY_W-1:0] delayCnt;
    logic longSel;
    logic porPending;
    reset_src_t lastSrc;
    logic subClkPrev;
    logic subTick;
    logic [7:0] threshold;
    logic [2:0] causeFlags;
    logic [7:0] flashCtrl2;
    logic [DATA_W-1:0] rdData;
    logic [DATA_W-1:0] rdWord;
    logic rdHit;
    logic setupPhase;
    logic accessPhase;
    logic wrAccess;
    logic pinLow;
    logic supplyArmed;
    logic supplyQual;
    logic codeQual;
    logic supplyTrig;
    logic codeTrig;
    logic wdtRunTrig;
    logic wdtSleepTrig;
    logic flashTrig;
    logic anyTrig;
    logic running;
    logic thrRestore;

    // threshold decode; bad codes arm the fault path
    always_comb begin
        case (threshold)
            THR_1V7: thresholdLevel = LVL_1V7;
            THR_1V9: thresholdLevel = LVL_1V9;
            THR_2V55: thresholdLevel = LVL_2V55;
            THR_3V15: thresholdLevel = LVL_3V15;
            THR_3V8: thresholdLevel = LVL_3V8;
            THR_OFF: thresholdLevel = LVL_OFF;
            default: thresholdLevel = LVL_BAD;
        endcase
    end

    // sub clock is a sampled level, only its rising edge counts
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            subClkPrev <= 1'b0;
        end else begin
            subClkPrev <= subClk;
        end
    end
    assign subTick = subClk && !subClkPrev;

    assign running = state == SEQ_RUN;
    assign pinLow = externalResetOptEn && !externalResetPinN;
    assign supplyArmed = !sleepMode && thresholdLevel != LVL_OFF
        && thresholdLevel != LVL_BAD;

    supply_qualifier u_supply_qual (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .subTick(subTick),
        .condition(supplyArmed && lowSupplyDetect),
        .target(LOW_SUPPLY_QUAL_TICKS),
        .qualified(supplyQual)
    );

    supply_qualifier u_code_qual (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .subTick(subTick),
        .condition(thresholdLevel == LVL_BAD),
        .target(CODE_FAULT_TICKS),
        .qualified(codeQual)
    );

    assign supplyTrig = supplyQual;
    assign codeTrig = codeQual;
    assign wdtRunTrig = watchdogTimeout && !sleepMode;
    // sleep expiry only restarts the core, no delay and no hold
    assign wdtSleepTrig = watchdogTimeout && sleepMode && running;
    assign anyTrig = pinLow || supplyTrig || codeTrig || wdtRunTrig
        || flashTrig || watchdogCodeFault;

    // sequencer: hold while a source stands, then time the release
    always_comb begin
        next_state = state;
        case (state)
            SEQ_RUN: begin
                if (anyTrig) begin
                    next_state = SEQ_HOLD;
                end
            end
            SEQ_HOLD: begin
                if (!anyTrig) begin
                    next_state = SEQ_DELAY;
                end
            end
            SEQ_DELAY: begin
                if (anyTrig) begin
                    next_state = SEQ_HOLD;
                end else if (delayCnt == '0) begin
                    next_state = SEQ_RUN;
                end
            end
            default: next_state = SEQ_HOLD;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= SEQ_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // power-on and supply resets take the long wait
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            delayCnt <= '0;
        end else if (state == SEQ_HOLD && next_state == SEQ_DELAY) begin
            if (longSel) begin
                delayCnt <= DELAY_W'(LONG_DELAY_CYC - 1);
            end else begin
                delayCnt <= DELAY_W'(SHORT_DELAY_CYC - 1);
            end
        end else if (state == SEQ_DELAY && delayCnt != '0) begin
            delayCnt <= delayCnt - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            longSel <= 1'b1;
        end else if (supplyTrig) begin
            longSel <= 1'b1;
        end else if (next_state == SEQ_RUN) begin
            longSel <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            porPending <= 1'b1;
        end else if (next_state == SEQ_RUN) begin
            porPending <= 1'b0;
        end
    end

    // most recent cause, for software diagnosis
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lastSrc <= SRC_POWER_ON;
        end else if (supplyTrig) begin
            lastSrc <= SRC_LOW_SUPPLY;
        end else if (codeTrig) begin
            lastSrc <= SRC_CODE_FAULT;
        end else if (watchdogCodeFault) begin
            lastSrc <= SRC_WDT_CTRL;
        end else if (wdtRunTrig || wdtSleepTrig) begin
            lastSrc <= SRC_WDT;
        end else if (flashTrig) begin
            lastSrc <= SRC_FLASH;
        end else if (pinLow) begin
            lastSrc <= SRC_PIN;
        end
    end

    // regInit restores table defaults, porInit also the rest
    always_comb begin
        rstCtrl.cpuHold = !running;
        rstCtrl.regInit = !running;
        rstCtrl.porInit = porPending;
        rstCtrl.pcSpClear = !running || wdtSleepTrig;
        rstCtrl.portsPreset = !running;
    end

    // set wins over clear-watchdog in the same cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            watchdogExpiredFlag <= 1'b0;
        end else if (wdtRunTrig || wdtSleepTrig) begin
            watchdogExpiredFlag <= 1'b1;
        end else if (clearWatchdog) begin
            watchdogExpiredFlag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            powerdownFlag <= 1'b0;
        end else if (wdtSleepTrig || haltExec) begin
            powerdownFlag <= 1'b1;
        end else if (clearWatchdog) begin
            powerdownFlag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            watchdogDivExp <= WDT_EXP_TABLE[0];
        end else begin
            watchdogDivExp <= WDT_EXP_TABLE[watchdogSelect];
        end
    end

    // register bus
    assign setupPhase = apbReq.psel && !apbReq.penable;
    assign accessPhase = apbReq.psel && apbReq.penable;
    assign wrAccess = accessPhase && apbReq.pwrite;
    assign flashTrig = wrAccess && apbReq.paddr == FLASH_CTRL2_OFS
        && apbReq.pwdata[7:0] == FLASH_RESET_KEY;

    // a supply reset keeps the level, every other one restores it
    assign thrRestore = codeTrig || (!running && !longSel);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            threshold <= THRESHOLD_RESET;
        end else if (thrRestore) begin
            threshold <= THRESHOLD_RESET;
        end else if (wrAccess && apbReq.paddr == THRESHOLD_OFS) begin
            threshold <= (threshold & ~THRESHOLD_WR_MASK)
                | (apbReq.pwdata[7:0] & THRESHOLD_WR_MASK);
        end
    end

    // flags survive every reset but power-on; zero writes clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            causeFlags <= CAUSE_RESET;
        end else begin
            if (supplyTrig) begin
                causeFlags[SUPPLY_FLAG_BIT] <= 1'b1;
            end else if (wrAccess && apbReq.paddr == CAUSE_OFS
                    && !apbReq.pwdata[SUPPLY_FLAG_BIT]) begin
                causeFlags[SUPPLY_FLAG_BIT] <= 1'b0;
            end
            if (codeTrig) begin
                causeFlags[CODE_FLAG_BIT] <= 1'b1;
            end else if (wrAccess && apbReq.paddr == CAUSE_OFS
                    && !apbReq.pwdata[CODE_FLAG_BIT]) begin
                causeFlags[CODE_FLAG_BIT] <= 1'b0;
            end
            if (watchdogCodeFault) begin
                causeFlags[WDT_CTRL_FLAG_BIT] <= 1'b1;
            end else if (wrAccess && apbReq.paddr == CAUSE_OFS
                    && !apbReq.pwdata[WDT_CTRL_FLAG_BIT]) begin
                causeFlags[WDT_CTRL_FLAG_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || rstCtrl.regInit) begin
            flashCtrl2 <= FLASH_CTRL2_RESET;
        end else if (wrAccess && apbReq.paddr == FLASH_CTRL2_OFS) begin
            flashCtrl2 <= apbReq.pwdata[7:0];
        end
    end

    always_comb begin
        rdData = '0;
        rdHit = 1'b1;
        if (apbReq.paddr == THRESHOLD_OFS) begin
            rdData[7:0] = threshold;
        end else if (apbReq.paddr == CAUSE_OFS) begin
            rdData[2:0] = causeFlags;
        end else if (apbReq.paddr == FLASH_CTRL2_OFS) begin
            rdData[7:0] = flashCtrl2;
        end else if (apbReq.paddr == STATUS_OFS) begin
            rdData[STAT_EXPIRED_BIT] = watchdogExpiredFlag;
            rdData[STAT_POWERDOWN_BIT] = powerdownFlag;
            rdData[STAT_ARMED_BIT] = supplyArmed;
            rdData[STAT_HOLD_BIT] = !running;
            rdData[STAT_SRC_LSB +: 3] = lastSrc;
        end else begin
            rdHit = 1'b0;
        end
    end

    // read word captured in setup so prdata comes from a flop
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdWord <= '0;
        end else if (setupPhase && !apbReq.pwrite) begin
            rdWord <= rdData;
        end
    end

    // one driver for the whole response word
    assign apbRsp = '{pready: 1'b1, pslverr: accessPhase && !rdHit,
        prdata: rdWord};

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_code_fault;
        codeTrig ##1 threshold == THRESHOLD_RESET;
    endsequence

    sequence s_sleep_expiry;
        wdtSleepTrig && rstCtrl.pcSpClear
            ##1 watchdogExpiredFlag && powerdownFlag;
    endsequence

    a_long_delay: assert property (
        state == SEQ_HOLD && next_state == SEQ_DELAY && longSel
        |=> delayCnt == DELAY_W'(LONG_DELAY_CYC - 1))
        else $error("long reset delay loaded wrong");
    a_short_delay: assert property (
        state == SEQ_HOLD && next_state == SEQ_DELAY && !longSel
        |=> delayCnt == DELAY_W'(SHORT_DELAY_CYC - 1))
        else $error("short reset delay loaded wrong");
    a_pin_option: assert property (
        running && !externalResetOptEn && !supplyTrig && !codeTrig
        && !wdtRunTrig && !flashTrig && !watchdogCodeFault
        |=> running)
        else $error("pin reset taken while option off");
    a_pin_hold: assert property (
        pinLow |=> rstCtrl.cpuHold && rstCtrl.pcSpClear
        && rstCtrl.portsPreset)
        else $error("pin low did not hold the core");
    a_sleep_off: assert property (
        sleepMode |-> !supplyArmed ##1 !$rose(causeFlags[SUPPLY_FLAG_BIT]))
        else $error("supply reset armed in sleep");
    a_code_restore: assert property (
        codeTrig |-> s_code_fault)
        else $error("bad threshold code not restored");
    a_supply_keep: assert property (
        supplyTrig && !running && longSel && !codeTrig
        && !wrAccess |=> $stable(threshold))
        else $error("supply reset changed the threshold");
    a_supply_flag: assert property (
        supplyTrig |=> causeFlags[SUPPLY_FLAG_BIT] && !running)
        else $error("supply reset flag not set");
    a_cause_upper: assert property (
        $past(setupPhase && !apbReq.pwrite && apbReq.paddr == CAUSE_OFS)
        |-> apbRsp.prdata[DATA_W-1:3] == '0)
        else $error("cause upper bits not zero");
    a_flash_reset: assert property (
        flashTrig |=> !running ##1 flashCtrl2 == FLASH_CTRL2_RESET)
        else $error("flash key did not reset");
    a_sleep_wdt: assert property (
        wdtSleepTrig |-> s_sleep_expiry)
        else $error("sleep expiry handled wrong");
    a_release_timed: assert property (
        state == SEQ_DELAY && delayCnt != '0 |=> !running)
        else $error("reset released before delay end");
endmodule : mcu_reset_controller

// File: sim/reset_pin_model.sv
// Purpose: external reset pin circuit with its pull-up
// Assumes: bench asks for a press of a given length
// Notes: a released pin goes to the pull-up level
`timescale 1ns/1ps
module reset_pin_model (
    // clock
    input wire logic ref_clk,
    // press request and length in cycles
    input wire logic pressReq,
    input wire logic [7:0] pressLen,
    // pin toward the device
    output logic pinN
);
    logic [7:0] left = 8'h00;
    always_ff @(posedge ref_clk) begin
        if (pressReq) begin
            left <= pressLen;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    // pull-up wins once nothing pulls low
    assign pinN = (left == 8'h00);
endmodule : reset_pin_model

// File: sim/testbench.sv
// Purpose: register and reset-source checks of the controller
// Assumes: delays shortened to 20 and 8 cycles
// Notes: sub clock runs at one eighth of ref_clk
`timescale 1ns/1ps
module testbench;
    import mcu_reset_pkg::*;
    localparam int LONG = 20;
    localparam int SHORT = 8;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    apb_req_t apbReq = '0;
    apb_rsp_t apbRsp;
    logic pinN, optEn = 1'b1, subClk = 1'b0, lowSup = 1'b0;
    logic sleep = 1'b0, wdtOut = 1'b0, clrWdt = 1'b0, press = 1'b0;
    logic wdtFault = 1'b0;
    logic [2:0] wdtSel = 3'h0;
    logic [1:0] subDiv = 2'h0;
    logic [4:0] divExp;
    logic [31:0] rd;
    logic err, expFlag, pdFlag;
    supply_level_t level;
    rst_ctrl_t rstCtrl;
    int miscompares = 0, total_checks = 0, n;
    int expTab[8] = '{8, 10, 12, 14, 15, 16, 17, 18};

    reset_pin_model reset_pin_model_i (.ref_clk(ref_clk),
        .pressReq(press), .pressLen(8'h05), .pinN(pinN));
    mcu_reset_controller #(.LONG_DELAY_CYC(LONG), .SHORT_DELAY_CYC(SHORT))
        mcu_reset_controller_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .apbReq(apbReq), .apbRsp(apbRsp), .externalResetPinN(pinN),
        .externalResetOptEn(optEn), .subClk(subClk),
        .lowSupplyDetect(lowSup), .thresholdLevel(level),
        .sleepMode(sleep), .haltExec(1'b0), .clearWatchdog(clrWdt),
        .watchdogTimeout(wdtOut), .watchdogCodeFault(wdtFault),
        .watchdogSelect(wdtSel), .watchdogDivExp(divExp),
        .rstCtrl(rstCtrl), .watchdogExpiredFlag(expFlag),
        .powerdownFlag(pdFlag));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        subDiv <= subDiv + 2'h1;
        if (subDiv == 2'h3) begin
            subClk <= ~subClk;
        end
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task chk(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // pready is sampled with the request held, never assumed
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        apbReq <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (apbRsp.pready !== 1'b1 && k < 20);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        if (apbRsp.pready !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
        apbReq <= '0;
    endtask : apb

    task await(input logic v, input int lim);
        n = 0;
        while (rstCtrl.cpuHold !== v) begin
            @(posedge ref_clk);
            n++;
            if (n > lim) begin
                miscompares++;
                report_and_stop();
            end
        end
    endtask : await

    task hold(input int c);
        repeat (c) @(posedge ref_clk);
    endtask : hold

    initial begin
        hold(16);
        chk("pc clear", 1, rstCtrl.pcSpClear);
        chk("por init", 1, rstCtrl.porInit);
        chk("ports preset", 1, rstCtrl.portsPreset);
        chk("flags", 0, {expFlag, pdFlag});
        sys_rst <= 1'b0;
        await(1'b0, LONG + 8);
        chk("power-on delay", 1, n >= LONG);
        apb(0, THRESHOLD_OFS, 0);
        chk("threshold", 32'h66, rd);
        apb(0, CAUSE_OFS, 0);
        chk("cause", 0, rd);
        apb(0, 12'h010, 0);
        chk("unmapped error", 1, err);
        apb(1, THRESHOLD_OFS, 32'h55);
        apb(0, THRESHOLD_OFS, 0);
        chk("threshold 1v9", 32'h55, rd);
        chk("level", LVL_1V9, level);
        for (int i = 0; i < 8; i++) begin
            wdtSel <= i[2:0];
            hold(3);
            chk("divider", expTab[i], {27'h0, divExp});
        end
        optEn <= 1'b0;
        press <= 1'b1;
        hold(1);
        press <= 1'b0;
        hold(10);
        chk("pin disabled", 0, rstCtrl.cpuHold);
        optEn <= 1'b1;
        press <= 1'b1;
        hold(1);
        press <= 1'b0;
        hold(3);
        chk("pin reset", 1, rstCtrl.pcSpClear);
        chk("reg init", 1, rstCtrl.regInit);
        chk("no por init", 0, rstCtrl.porInit);
        await(1'b0, 60);
        chk("pin delay", 1, n >= SHORT);
        // the threshold is not in the kept subset
        apb(0, THRESHOLD_OFS, 0);
        chk("pin threshold", 32'h66, rd);
        apb(1, FLASH_CTRL2_OFS, 32'h55);
        hold(2);
        chk("flash reset", 1, rstCtrl.cpuHold);
        await(1'b0, 60);
        wdtOut <= 1'b1;
        hold(1);
        wdtOut <= 1'b0;
        hold(2);
        chk("wdt hold", 1, rstCtrl.cpuHold);
        chk("wdt flags", 2'h2, {expFlag, pdFlag});
        await(1'b0, 60);
        clrWdt <= 1'b1;
        hold(1);
        clrWdt <= 1'b0;
        sleep <= 1'b1;
        wdtOut <= 1'b1;
        hold(1);
        wdtOut <= 1'b0;
        hold(2);
        chk("sleep run", 0, rstCtrl.cpuHold);
        chk("sleep flags", 2'h3, {expFlag, pdFlag});
        apb(0, STATUS_OFS, 0);
        chk("status", 32'h33, rd);
        lowSup <= 1'b1;
        hold(60);
        chk("sleep supply", 0, rstCtrl.cpuHold);
        lowSup <= 1'b0;
        sleep <= 1'b0;
        clrWdt <= 1'b1;
        hold(1);
        clrWdt <= 1'b0;
        lowSup <= 1'b1;
        hold(6);
        lowSup <= 1'b0;
        hold(30);
        chk("short dip", 0, rstCtrl.cpuHold);
        // bits 3:2 stay 01, so the code becomes F7h, undefined
        apb(1, THRESHOLD_OFS, 32'hFF);
        await(1'b1, 40);
        await(1'b0, 60);
        apb(0, THRESHOLD_OFS, 0);
        chk("restored", 32'h66, rd);
        apb(0, CAUSE_OFS, 0);
        chk("code fault", 32'h02, rd);
        apb(1, THRESHOLD_OFS, 32'h55);
        lowSup <= 1'b1;
        await(1'b1, 60);
        lowSup <= 1'b0;
        await(1'b0, LONG + 20);
        apb(0, THRESHOLD_OFS, 0);
        chk("kept code", 32'h55, rd);
        apb(1, CAUSE_OFS, 32'h07);
        apb(0, CAUSE_OFS, 0);
        chk("supply flag", 32'h06, rd);
        apb(1, CAUSE_OFS, 32'h00);
        apb(0, CAUSE_OFS, 0);
        chk("cleared", 0, rd);
        wdtFault <= 1'b1;
        hold(1);
        wdtFault <= 1'b0;
        await(1'b1, 4);
        await(1'b0, 60);
        apb(0, CAUSE_OFS, 0);
        chk("wdt ctrl flag", 32'h01, rd);
        report_and_stop();
    end
endmodule : testbench
